//--- core/fault_syndrome_encoder.sv
// syndrome assembly, matrix trap routing and register port
//
// Contract
// RULE1 - walk external aborts at levels 1..3 encode 0x15, 0x16, 0x17.
// RULE2 - parity or ECC error on ordinary access encodes 0x18.
// RULE3 - walk parity errors use 0x1B..0x1F only without reliability extension.
// RULE4 - realm walk granule faults levels 0..3 0x24..0x27; level -1 0x23 needs LPA.
// RULE5 - realm non-walk granule fault encodes 0x28.
// RULE6 - with large addresses, level -1 size fault 0x29, translation 0x2B.
// RULE7 - reserved fault status codes are never produced.
// RULE8 - no access flag or permission faults at level 0.
// RULE9 - with stage1 walk bit set, level is that of stage 2 translation.
// RULE10 - syndrome fields need no defined value after warm reset.
// RULE11 - with hardware flag management, atomic update fault encodes 0x31.
// RULE12 - matrix trap covers matrix insns, streaming vector insns, matrix sysregs.
// RULE13 - matrix syndrome bits 24:2 zero, reason code in bits 1:0.
// RULE14 - reason: 0 enable trap, 1 streaming vector, 2 not streaming, 3 array off.
// RULE15 - matrix traps report class 0x1D.
// RULE16 - level1 enable to EL1, level2 controls to EL2, level3 to EL3.
// RULE17 - granule syndrome bits 24:22 zero; bit 21 marks stage 2 walk.
// RULE18 - granule syndrome bit 20 is one for instruction, zero for data.
// RULE19 - status in 19:14; table size faults 0,1; walk faults 4,5.
// RULE20 - granule faults 0x0C, 0x0D; fetch external aborts 0x14, 0x15.
// RULE21 - with redirection, bit 13 marks redirected register move faults.
// RULE22 - bit 13 zero in level1 syndrome and when instruction bit set.
// RULE23 - bit 8 marks cache maintenance or address translation aborts.
// RULE24 - cache maint bit set only for those; zeroing insns never set it.
// RULE25 - layout follows exception class; unused positions zero.
//
// Strobed register access and the address map were left to the implementer.
module fault_syndrome_encoder
	import fault_syndrome_pkg::*;
#(
	parameter bit         HAS_RAS        = 1'b1,
	parameter bit         HAS_RME        = 1'b1,
	parameter bit         HAS_LPA2       = 1'b1,
	parameter bit         HAS_HAFDBS     = 1'b1,
	parameter bit         HAS_NV2        = 1'b1,
	parameter logic [5:0] EC_IABT_LOWER  = 6'h20,
	parameter logic [5:0] EC_IABT_SAME   = 6'h21,
	parameter logic [5:0] EC_DABT_LOWER  = 6'h24,
	parameter logic [5:0] EC_DABT_SAME   = 6'h25,
	parameter logic [5:0] EC_GPC         = 6'h1E
) (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        ce_in,
	input  wire logic        abort_valid_in,
	input  wire abort_req_t  abort_in,
	input  wire logic        gpc_valid_in,
	input  wire gpc_req_t    gpc_in,
	input  wire logic        matrix_valid_in,
	input  wire matrix_req_t matrix_in,
	input  wire logic        streaming_mode_state_in,
	input  wire logic        array_storage_state_in,
	input  wire logic [3:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic [31:0]      rdata_out,
	output syndrome_t        syndrome_out,
	output logic             take_out,
	output logic [1:0]       target_el_out,
	output logic             drop_out
);

	syndrome_t  synd_q;
	syndrome_t  synd_d;
	logic       take_q;
	logic       take_d;
	logic [1:0] el_q;
	logic [1:0] el_d;
	logic       drop_q;
	logic       drop_d;
	logic [3:0] ctrl_q;
	logic       valid_q;
	logic       drop_st_q;
	logic [31:0] rdata_q;

	logic [5:0] fsc_code;
	logic       fsc_legal;

	fsc_encoder #(
		.HAS_RAS    (HAS_RAS),
		.HAS_RME    (HAS_RME),
		.HAS_LPA2   (HAS_LPA2),
		.HAS_HAFDBS (HAS_HAFDBS)
	) u_fsc (
		.kind_in   (abort_in.kind),
		.level_in  (abort_in.level),
		.code_out  (fsc_code),
		.legal_out (fsc_legal)
	);

	// matrix trap decision
	logic       m_trap;
	logic [1:0] m_reason;
	logic [1:0] m_el;
	logic       en1_off;
	logic       en2_off;
	logic       en3_off;
	logic       en_trap;

	always_comb begin
		en1_off  = !ctrl_q[CTRL_L1EN] && (matrix_in.cur_el <= EL1);
		en2_off  = (!ctrl_q[CTRL_L2EN] || ctrl_q[CTRL_L2TRP]) &&
		           (matrix_in.cur_el <= EL2);
		en3_off  = !ctrl_q[CTRL_L3EN];
		en_trap  = en1_off || en2_off || en3_off;
		m_el     = EL3; // RULE16
		if (en1_off) begin
			m_el = EL1; // RULE16
		end else if (en2_off) begin
			m_el = EL2; // RULE16
		end
		if (matrix_in.cur_el > m_el) begin
			m_el = matrix_in.cur_el;
		end
		m_trap   = 1'b0;
		m_reason = MTR_ENABLE;
		if (en_trap) begin
			m_trap   = 1'b1; // RULE12
			m_reason = MTR_ENABLE; // RULE14
		end else if (matrix_in.kind == MK_VEC_INSN) begin
			m_trap   = streaming_mode_state_in; // RULE12
			m_reason = MTR_VEC_SM; // RULE14
			m_el     = matrix_in.cur_el;
		end else if (matrix_in.kind == MK_MATRIX_INSN) begin
			m_trap   = !streaming_mode_state_in || !array_storage_state_in;
			m_reason = !streaming_mode_state_in ? MTR_NOT_SM : MTR_ZA_OFF;
			m_el     = matrix_in.cur_el;
		end
		if (m_el == EL0) begin
			m_el = EL1;
		end
	end

	// syndrome assembly: one event per cycle, abort first, then check, then matrix
	logic [5:0] gcsc;

	always_comb begin
		gcsc = 6'h00;
		unique case (gpc_in.kind)
			GK_ASZ:  gcsc = GCSC_ASZ_L0; // RULE19
			GK_WALK: gcsc = GCSC_WALK_L0; // RULE19
			GK_GPF:  gcsc = GCSC_GPF_L0; // RULE20
			GK_SEA:  gcsc = GCSC_SEA_L0; // RULE20
		endcase
		gcsc = gcsc + {5'h00, gpc_in.level1};
	end

	always_comb begin
		synd_d = '0; // RULE25
		take_d = 1'b0;
		el_d   = el_q;
		drop_d = 1'b0;
		if (abort_valid_in) begin
			if (fsc_legal) begin
				take_d = 1'b1;
				el_d   = abort_in.target_el;
				if (abort_in.insn) begin
					synd_d.ec = abort_in.lower_el ? EC_IABT_LOWER : EC_IABT_SAME;
				end else begin
					synd_d.ec = abort_in.lower_el ? EC_DABT_LOWER : EC_DABT_SAME;
					// zeroing ops are not cache maintenance
					synd_d.iss[CM_BIT] = abort_in.cache_maint &&
					                     !abort_in.zeroing; // RULE23 RULE24
				end
				// the level arrives already as the stage 2 walk level
				synd_d.iss[STAGE1_WALK_FAULT_BIT_BIT] = abort_in.s1walk; // RULE9
				synd_d.iss[FSC_LSB +: FSC_W] = fsc_code; // RULE7
			end else begin
				drop_d = 1'b1; // RULE7
			end
		end else if (gpc_valid_in) begin
			take_d = 1'b1;
			el_d   = gpc_in.target_el;
			synd_d.ec = EC_GPC; // RULE25
			synd_d.iss[STAGE2_WALK_FAULT_BIT_BIT] = gpc_in.s2walk; // RULE17
			synd_d.iss[IND_BIT]   = gpc_in.instr; // RULE18
			synd_d.iss[GCSC_LSB +: FSC_W] = gcsc; // RULE19 RULE20
			synd_d.iss[REDIR_BIT] = HAS_NV2 && gpc_in.redirect &&
			                        !gpc_in.instr &&
			                        (gpc_in.target_el != EL1); // RULE21 RULE22
		end else if (matrix_valid_in && m_trap) begin
			take_d = 1'b1;
			el_d   = m_el;
			synd_d.ec = EC_MATRIX; // RULE15
			synd_d.iss[MTR_LSB +: 2] = m_reason; // RULE13
		end
	end

	// syndrome resets to zero although none is required; target level resets to EL1
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			synd_q <= '0; // RULE10
			el_q   <= EL1;
		end else if (ce_in && take_d) begin
			synd_q <= synd_d;
			el_q   <= el_d;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			take_q <= 1'b0;
			drop_q <= 1'b0;
		end else if (ce_in) begin
			take_q <= take_d;
			drop_q <= drop_d;
		end
	end

	// registers
	logic wr_ctrl;
	logic wr_status;
	logic rd_synd;

	assign wr_ctrl   = wr_in && (addr_in == OFS_CTRL);
	assign wr_status = wr_in && (addr_in == OFS_STATUS);
	assign rd_synd   = rd_in && (addr_in == OFS_SYND);

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_q <= CTRL_RST;
		end else if (ce_in && wr_ctrl) begin
			ctrl_q <= wdata_in[3:0];
		end
	end

	// a new capture in the clearing cycle keeps its flag
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			valid_q   <= 1'b0;
			drop_st_q <= 1'b0;
		end else if (ce_in) begin
			if (take_d) begin
				valid_q <= 1'b1;
			end else if (rd_synd) begin
				valid_q <= 1'b0;
			end
			if (drop_d) begin
				drop_st_q <= 1'b1;
			end else if (wr_status && wdata_in[ST_DROP]) begin
				drop_st_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (ce_in) begin
			rdata_q <= 32'h0000_0000;
			if (rd_in) begin
				unique case (addr_in)
					OFS_SYND:   rdata_q <= {1'b0, synd_q};
					OFS_CTRL:   rdata_q <= {28'h000_0000, ctrl_q};
					OFS_STATUS: rdata_q <= {28'h000_0000, el_q,
					                        drop_st_q, valid_q};
					default:    rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign rdata_out     = rdata_q;
	assign syndrome_out  = synd_q;
	assign take_out      = take_q;
	assign target_el_out = el_q;
	assign drop_out      = drop_q;

	// checks
	property p_walk_sea;
		@(posedge clk_in) disable iff (!arst_n_in)
		(ce_in && abort_valid_in && abort_in.kind == FK_SEA_WALK &&
		 abort_in.level == LVL_3) |=> (synd_q.iss[5:0] == 6'h17);
	endproperty
	a_walk_sea: assert property (p_walk_sea) // RULE1
		else $error("walk abort level 3 code wrong");

	property p_ecc_ras;
		@(posedge clk_in) disable iff (!arst_n_in)
		(ce_in && abort_valid_in && abort_in.kind == FK_ECC_WALK && HAS_RAS)
		|=> drop_q && !take_q;
	endproperty
	a_ecc_ras: assert property (p_ecc_ras) // RULE3
		else $error("walk parity code emitted with reliability extension");

	property p_no_l0_perm;
		@(posedge clk_in) disable iff (!arst_n_in)
		take_q && (synd_q.ec != EC_MATRIX) && (synd_q.ec != EC_GPC) |->
		(synd_q.iss[5:0] != 6'h08) && (synd_q.iss[5:0] != 6'h0C);
	endproperty
	a_no_l0_perm: assert property (p_no_l0_perm) // RULE8
		else $error("level 0 access flag or permission code");

	property p_matrix_layout;
		@(posedge clk_in) disable iff (!arst_n_in)
		take_q && (synd_q.ec == EC_MATRIX) |-> (synd_q.iss[24:2] == '0);
	endproperty
	a_matrix_layout: assert property (p_matrix_layout) // RULE13
		else $error("matrix syndrome upper bits not zero");

	property p_matrix_el1;
		@(posedge clk_in) disable iff (!arst_n_in)
		(ce_in && matrix_valid_in && !abort_valid_in && !gpc_valid_in &&
		 !ctrl_q[CTRL_L1EN] && matrix_in.cur_el == EL0)
		|=> take_q && (target_el_out == EL1) && (synd_q.iss[1:0] == 2'h0);
	endproperty
	a_matrix_el1: assert property (p_matrix_el1) // RULE16
		else $error("level1 matrix trap not routed to EL1");

	property p_gpc_upper;
		@(posedge clk_in) disable iff (!arst_n_in)
		take_q && (synd_q.ec == EC_GPC) |->
		(synd_q.iss[24:22] == 3'h0) &&
		(synd_q.iss[12:0] == 13'h0000);
	endproperty
	a_gpc_upper: assert property (p_gpc_upper) // RULE17
		else $error("granule syndrome reserved bits set");

	property p_gpc_ind;
		@(posedge clk_in) disable iff (!arst_n_in)
		(ce_in && gpc_valid_in && !abort_valid_in) |=>
		(synd_q.iss[20] == $past(gpc_in.instr)) &&
		(synd_q.iss[21] == $past(gpc_in.s2walk));
	endproperty
	a_gpc_ind: assert property (p_gpc_ind) // RULE18
		else $error("granule instruction or walk bit wrong");

	property p_redir_zero;
		@(posedge clk_in) disable iff (!arst_n_in)
		take_q && (synd_q.ec == EC_GPC) &&
		(synd_q.iss[20] || target_el_out == EL1) |-> !synd_q.iss[13];
	endproperty
	a_redir_zero: assert property (p_redir_zero) // RULE22
		else $error("redirect bit set where it must be zero");

	property p_cm_zeroing;
		@(posedge clk_in) disable iff (!arst_n_in)
		(ce_in && abort_valid_in && fsc_legal && abort_in.zeroing) |=>
		!synd_q.iss[8];
	endproperty
	a_cm_zeroing: assert property (p_cm_zeroing) // RULE24
		else $error("zeroing instruction set cache maint bit");

	property p_valid_hold;
		@(posedge clk_in) disable iff (!arst_n_in)
		(ce_in && (take_d || rd_synd)) |=> (valid_q == $past(take_d));
	endproperty
	a_valid_hold: assert property (p_valid_hold) // capture wins over a same-cycle read clear
		else $error("capture flag lost");

endmodule

//--- core/fault_syndrome_pkg.sv
// shared constants, types and register map for the fault syndrome encoder
package fault_syndrome_pkg;

	localparam int ISS_W = 25;
	localparam int EC_W  = 6;
	localparam int FSC_W = 6;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// fault status codes
	localparam logic [5:0] FSC_ASZ_L0       = 6'h00;
	localparam logic [5:0] FSC_XLT_L0       = 6'h04;
	localparam logic [5:0] FSC_AFLAG_L0     = 6'h08;
	localparam logic [5:0] FSC_PERM_L0      = 6'h0C;
	localparam logic [5:0] FSC_SEA          = 6'h10;
	localparam logic [5:0] FSC_SEA_WALK_LM1 = 6'h11;
	localparam logic [5:0] FSC_SEA_WALK_L0  = 6'h14;
	localparam logic [5:0] FSC_ECC          = 6'h18;
	localparam logic [5:0] FSC_ECC_WALK_LM1 = 6'h1B;
	localparam logic [5:0] FSC_GPF_WALK_LM1 = 6'h23;
	localparam logic [5:0] FSC_GPF_WALK_L0  = 6'h24;
	localparam logic [5:0] FSC_GPF          = 6'h28;
	localparam logic [5:0] FSC_ASZ_LM1      = 6'h29;
	localparam logic [5:0] FSC_XLT_LM1      = 6'h2B;
	localparam logic [5:0] FSC_TLB_CONFLICT = 6'h30;
	localparam logic [5:0] FSC_ATOMIC_HW    = 6'h31;

	// granule check status codes, level 0 forms; level 1 adds one
	localparam logic [5:0] GCSC_ASZ_L0  = 6'h00;
	localparam logic [5:0] GCSC_WALK_L0 = 6'h04;
	localparam logic [5:0] GCSC_GPF_L0  = 6'h0C;
	localparam logic [5:0] GCSC_SEA_L0  = 6'h14;

	// matrix trap reason codes and class
	localparam logic [1:0] MTR_ENABLE   = 2'h0;
	localparam logic [1:0] MTR_VEC_SM   = 2'h1;
	localparam logic [1:0] MTR_NOT_SM   = 2'h2;
	localparam logic [1:0] MTR_ZA_OFF   = 2'h3;
	localparam logic [5:0] EC_MATRIX    = 6'h1D;

	// syndrome field positions
	localparam int FSC_LSB   = 0;
	localparam int STAGE1_WALK_FAULT_BIT_BIT = 7;
	localparam int CM_BIT    = 8;
	localparam int REDIR_BIT = 13;
	localparam int GCSC_LSB  = 14;
	localparam int IND_BIT   = 20;
	localparam int STAGE2_WALK_FAULT_BIT_BIT = 21;
	localparam int MTR_LSB   = 0;

	// level index: 0 means level -1, 4 means level 3
	localparam logic [2:0] LVL_M1 = 3'h0;
	localparam logic [2:0] LVL_0  = 3'h1;
	localparam logic [2:0] LVL_3  = 3'h4;

	// register map
	localparam logic [3:0] OFS_SYND   = 4'h0;
	localparam logic [3:0] OFS_CTRL   = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] CTRL_RST   = 4'h0;
	localparam int CTRL_L1EN  = 0;
	localparam int CTRL_L2EN  = 1;
	localparam int CTRL_L2TRP = 2;
	localparam int CTRL_L3EN  = 3;
	localparam int ST_VALID   = 0;
	localparam int ST_DROP    = 1;
	localparam int ST_EL_LSB  = 2;

	localparam logic [1:0] EL0 = 2'h0;
	localparam logic [1:0] EL1 = 2'h1;
	localparam logic [1:0] EL2 = 2'h2;
	localparam logic [1:0] EL3 = 2'h3;

	typedef enum logic [3:0] {
		FK_ASZ, FK_XLT, FK_AFLAG, FK_PERM, FK_SEA, FK_SEA_WALK, FK_ECC,
		FK_ECC_WALK, FK_GPF_WALK, FK_GPF, FK_TLB, FK_ATOMIC_HW
	} fault_kind_t;

	typedef enum logic [1:0] {
		GK_ASZ, GK_WALK, GK_GPF, GK_SEA
	} gpc_kind_t;

	typedef enum logic [1:0] {
		MK_MATRIX_INSN, MK_VEC_INSN, MK_SYSREG
	} matrix_kind_t;

	typedef struct packed {
		logic        insn;
		logic        lower_el;
		fault_kind_t kind;
		logic [2:0]  level;
		logic        s1walk;
		logic        cache_maint;
		logic        zeroing;
		logic [1:0]  target_el;
	} abort_req_t;

	typedef struct packed {
		logic       s2walk;
		logic       instr;
		gpc_kind_t  kind;
		logic       level1;
		logic       redirect;
		logic [1:0] target_el;
	} gpc_req_t;

	typedef struct packed {
		matrix_kind_t kind;
		logic [1:0]   cur_el;
	} matrix_req_t;

	typedef struct packed {
		logic [EC_W-1:0]  ec;
		logic [ISS_W-1:0] iss;
	} syndrome_t;

endpackage

//--- core/fsc_encoder.sv
// fault status code lookup with feature gating and reserved-code rejection
module fsc_encoder
	import fault_syndrome_pkg::*;
#(
	parameter bit HAS_RAS    = 1'b1,
	parameter bit HAS_RME    = 1'b1,
	parameter bit HAS_LPA2   = 1'b1,
	parameter bit HAS_HAFDBS = 1'b1
) (
	input  wire fault_kind_t kind_in,
	input  wire logic [2:0]  level_in,
	output logic [5:0]       code_out,
	output logic             legal_out
);

	logic [5:0] off;
	logic       lm1;
	logic       lgood;
	logic       l0;

	always_comb begin
		off       = {3'h0, level_in} - 6'h01;
		lm1       = (level_in == LVL_M1);
		l0        = (level_in == LVL_0);
		lgood     = (level_in <= LVL_3);
		code_out  = 6'h00;
		legal_out = 1'b0;
		unique case (kind_in)
			FK_ASZ: begin
				code_out  = lm1 ? FSC_ASZ_LM1 : FSC_ASZ_L0 + off; // RULE6
				legal_out = lgood && (!lm1 || HAS_LPA2); // RULE7
			end
			FK_XLT: begin
				code_out  = lm1 ? FSC_XLT_LM1 : FSC_XLT_L0 + off; // RULE6
				legal_out = lgood && (!lm1 || HAS_LPA2);
			end
			FK_AFLAG: begin
				code_out  = FSC_AFLAG_L0 + off;
				legal_out = lgood && !lm1 && !l0; // RULE8
			end
			FK_PERM: begin
				code_out  = FSC_PERM_L0 + off;
				legal_out = lgood && !lm1 && !l0; // RULE8
			end
			FK_SEA: begin
				code_out  = FSC_SEA;
				legal_out = 1'b1;
			end
			FK_SEA_WALK: begin
				code_out  = lm1 ? FSC_SEA_WALK_LM1 : FSC_SEA_WALK_L0 + off; // RULE1
				legal_out = lgood && (!lm1 || HAS_LPA2);
			end
			FK_ECC: begin
				code_out  = FSC_ECC; // RULE2
				legal_out = 1'b1;
			end
			FK_ECC_WALK: begin
				code_out  = FSC_ECC_WALK_LM1 + {3'h0, level_in}; // RULE3
				legal_out = lgood && !HAS_RAS; // RULE3
			end
			FK_GPF_WALK: begin
				code_out  = lm1 ? FSC_GPF_WALK_LM1 : FSC_GPF_WALK_L0 + off; // RULE4
				legal_out = HAS_RME && lgood && (!lm1 || HAS_LPA2); // RULE4
			end
			FK_GPF: begin
				code_out  = FSC_GPF; // RULE5
				legal_out = HAS_RME;
			end
			FK_TLB: begin
				code_out  = FSC_TLB_CONFLICT;
				legal_out = 1'b1;
			end
			FK_ATOMIC_HW: begin
				code_out  = FSC_ATOMIC_HW; // RULE11
				legal_out = HAS_HAFDBS; // RULE11
			end
			default: begin
				code_out  = 6'h00;
				legal_out = 1'b0; // RULE7
			end
		endcase
	end

endmodule

//--- tb/fault_source_model.sv
// partner model: pipeline and memory management fault sources
module fault_source_model
	import fault_syndrome_pkg::*;
(
	input  wire logic   clk_in,
	output logic        abort_valid_out,
	output abort_req_t  abort_out,
	output logic        gpc_valid_out,
	output gpc_req_t    gpc_out,
	output logic        matrix_valid_out,
	output matrix_req_t matrix_out
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		abort_valid_out = 1'b0;
		gpc_valid_out = 1'b0;
		matrix_valid_out = 1'b0;
		abort_out = '0;
		gpc_out = '0;
		matrix_out = '0;
	end

	// one-cycle event pulses; v[0] abort, v[1] gpc, v[2] matrix
	// abort level is already the stage 2 level when s1walk is set
	task automatic send(input logic [2:0] v, input abort_req_t a,
		input gpc_req_t g, input matrix_req_t m);
		@(posedge clk_in);
		abort_valid_out <= v[0];
		gpc_valid_out <= v[1];
		matrix_valid_out <= v[2];
		abort_out <= a;
		gpc_out <= g;
		matrix_out <= m;
		@(posedge clk_in);
		abort_valid_out <= 1'b0;
		gpc_valid_out <= 1'b0;
		matrix_valid_out <= 1'b0;
		// released buses show garbage, never the stale request
		abort_out <= ~a;
		gpc_out <= ~g;
		matrix_out <= ~m;
	endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the fault syndrome encoder
module tb_top
	import fault_syndrome_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk, arst_n, ce, av, gv, mv, sm, za, wr, rd, take, drop;
	abort_req_t  a;
	gpc_req_t    g;
	matrix_req_t m;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, d;
	syndrome_t   syn;
	logic [1:0]  tel;
	logic [30:0] exp_syn;
	int          fail_count, tests_run, i;
	logic [7:0]  mx_tab [7] = '{8'h01, 8'h05, 8'h12, 8'h37, 8'h0F, 8'h0A,
		8'hF2};

	fault_syndrome_encoder fault_syndrome_encoder_i (.clk_in(clk),
		.arst_n_in(arst_n), .ce_in(ce), .abort_valid_in(av),
		.abort_in(a), .gpc_valid_in(gv), .gpc_in(g),
		.matrix_valid_in(mv), .matrix_in(m),
		.streaming_mode_state_in(sm), .array_storage_state_in(za),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .syndrome_out(syn), .take_out(take),
		.target_el_out(tel), .drop_out(drop));

	fault_source_model fault_source_model_i (.clk_in(clk),
		.abort_valid_out(av), .abort_out(a), .gpc_valid_out(gv),
		.gpc_out(g), .matrix_valid_out(mv), .matrix_out(m));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		if (fail_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr_reg(input logic [3:0] ad, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= ad;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] ad, output logic [31:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= ad;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	// reference fault status code, -1 when the event must be dropped
	function automatic int exp_fsc(int k, int l);
		if (l > 4)
			return -1;
		case (k)
			0: return l == 0 ? 'h29 : l - 1;
			1: return l == 0 ? 'h2B : 'h04 + l - 1;
			2: return l < 2 ? -1 : 'h08 + l - 1;
			3: return l < 2 ? -1 : 'h0C + l - 1;
			4: return 'h10;
			5: return l == 0 ? 'h11 : 'h14 + l - 1;
			6: return 'h18;
			7: return -1;
			8: return l == 0 ? 'h23 : 'h24 + l - 1;
			9: return 'h28;
			10: return 'h30;
			default: return 'h31;
		endcase
	endfunction

	task automatic do_abort(input logic [2:0] v, input abort_req_t r);
		int f;
		logic [5:0] ec;
		f = exp_fsc(int'(r.kind), int'(r.level));
		fault_source_model_i.send(v, r, 8'($urandom), 4'($urandom));
		#1;
		check(take, f >= 0);
		check(drop, f < 0);
		if (f >= 0) begin
			ec = r.insn ? (r.lower_el ? 6'h20 : 6'h21)
				: (r.lower_el ? 6'h24 : 6'h25);
			exp_syn = {ec, 16'h0, !r.insn && r.cache_maint && !r.zeroing,
				r.s1walk, 1'b0, 6'(f)};
			check(tel, r.target_el);
		end
		check(syn, exp_syn);
	endtask

	task automatic do_mx(input matrix_req_t r, input logic [1:0] why,
		input logic [1:0] el, input bit chk_el);
		fault_source_model_i.send(3'h4, '0, '0, r);
		#1;
		check(take, 1'b1);
		exp_syn = {6'h1D, 23'h0, why};
		check(syn, exp_syn);
		if (chk_el)
			check(tel, el);
	endtask

	initial begin
		#1_000_000;
		fail_count++;
		wrap_up();
	end

	initial begin
		abort_req_t ra;
		gpc_req_t rg;
		fail_count = 0;
		tests_run = 0;
		arst_n = 1'b0;
		ce = 1'b1;
		sm = 1'b0;
		za = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		exp_syn = '0;
		void'($urandom(13));
		repeat (15) @(posedge clk);
		#1;
		check({syn, take, drop, tel}, 35'h1);
		@(posedge clk);
		arst_n <= 1'b1;
		rd_reg(4'h4, d);
		check(d, 32'h0);
		rd_reg(4'hC, d);
		check(d, 32'h0);
		for (i = 0; i < 240; i++) begin
			ra = $bits(ra)'($urandom);
			ra.kind = fault_kind_t'($urandom_range(11, 0));
			ra.level = 3'($urandom_range(4, 0));
			// raise the gpc and matrix sources too: abort must win
			do_abort(i % 8 == 0 ? 3'h7 : 3'h1, ra);
		end
		ra.kind = FK_SEA_WALK;
		ra.level = 3'h5;
		do_abort(3'h1, ra);
		rd_reg(4'h8, d);
		check(d[1], 1'b1);
		wr_reg(4'h8, 32'h2);
		rd_reg(4'h8, d);
		check(d[1], 1'b0);
		for (i = 0; i < 32; i++) begin
			rg = $bits(rg)'($urandom);
			rg.kind = gpc_kind_t'(i % 4);
			rg.level1 = 1'((i / 4) % 2);
			fault_source_model_i.send(i % 5 == 0 ? 3'h6 : 3'h2, '0, rg,
				'0);
			#1;
			exp_syn = {6'h1E, 3'h0, rg.s2walk, rg.instr,
				6'(rg.level1 + (i % 4 == 3 ? 6'h14 : i % 4 == 2 ? 6'h0C
				: i % 4 == 1 ? 6'h04 : 6'h00)),
				rg.redirect && !rg.instr && rg.target_el != EL1, 13'h0};
			check(syn, exp_syn);
			check(tel, rg.target_el);
		end
		rd_reg(4'h8, d);
		check(d[3:0], {rg.target_el, 2'b01});
		rd_reg(4'h0, d);
		check(d, {1'b0, exp_syn});
		rd_reg(4'h8, d);
		check(d[0], 1'b0);
		// table: ctrl, current level, expected target level
		for (i = 0; i < 7; i++) begin
			wr_reg(4'h4, {28'h0, mx_tab[i][7:4]});
			rd_reg(4'h4, d);
			check(d, {28'h0, mx_tab[i][7:4]});
			do_mx({matrix_kind_t'(i % 3), mx_tab[i][3:2]}, 2'h0,
				mx_tab[i][1:0], 1'b1);
		end
		wr_reg(4'h4, 32'hB);
		sm <= 1'b1;
		do_mx({MK_VEC_INSN, EL0}, 2'h1, 2'h0, 1'b0);
		@(posedge clk);
		sm <= 1'b0;
		do_mx({MK_MATRIX_INSN, EL0}, 2'h2, 2'h0, 1'b0);
		@(posedge clk);
		sm <= 1'b1;
		za <= 1'b0;
		do_mx({MK_MATRIX_INSN, EL1}, 2'h3, 2'h0, 1'b0);
		@(posedge clk);
		ce <= 1'b0;
		ra.kind = FK_TLB;
		fault_source_model_i.send(3'h1, ra, '0, '0);
		#1;
		check(take, 1'b0);
		check(syn, exp_syn);
		@(posedge clk);
		ce <= 1'b1;
		wrap_up();
	end
endmodule
